/* rtl/xf_cfg.svh */
`ifndef XF_CFG_SVH
`define XF_CFG_SVH

// ****************************************************************
// widths
// ****************************************************************
`define XF_IR_W 16
`define XF_DL_W 8
`define XF_SEL_W 4
`define XF_KN_SEL_W 3
`define XF_STB_W 7
`define XF_CMD_W 4

// ****************************************************************
// transform command field codes
// ****************************************************************
`define XF_CMD_NOP 4'h0
`define XF_CMD_TMA 4'h1
`define XF_CMD_TMAK 4'h2
`define XF_CMD_TK 4'h3
`define XF_CMD_TN 4'h4
`define XF_CMD_GIT_J 4'h5
`define XF_CMD_GIT_XT 4'h6

// ****************************************************************
// strobe field match, 011xxxx
// ****************************************************************
`define XF_STB_PAT 3'h3
`define XF_STB_HI 6
`define XF_STB_LO 4

// ****************************************************************
// selector positions and fixed figures
// ****************************************************************
`define XF_POS_ZERO 4'h5
`define XF_POS_SRC 4'h7
`define XF_POS_SK 4'h8
`define XF_POS_SH 4'h9
`define XF_POS_IR 4'ha
`define XF_POS_F 4'hb
`define XF_POS_IM 4'hc
`define XF_POS_F1 4'hd
`define XF_POS_F1A 4'he
`define XF_POS_FM 4'hf
`define XF_KN_AUTO 3'h7
`define XF_F_ZERO 4'h0
`define XF_F1_SK 4'h1
`define XF_F1_IR 4'h8
`define XF_F1_SH 4'hf
`define XF_IND_PAT 2'h0

`endif

/* rtl/xf_pkg.sv */
`include "xf_cfg.svh"

package xf_pkg;

  // ****************************************************************
  // microinstruction fields seen by the transform
  // ****************************************************************
  typedef struct packed {
    logic [`XF_CMD_W-1:0] cmd;
    logic [`XF_STB_W-1:0] strobe;
    logic [`XF_SEL_W-1:0] j;
  } xf_mir_t;

  // ****************************************************************
  // decoded special conditions
  // ****************************************************************
  typedef struct packed {
    logic ind_b;
    logic prot_c;
    logic dz_d;
  } xf_cond_t;

  // ****************************************************************
  // microcycle timing phases
  // ****************************************************************
  typedef enum logic [3:0] {
    XF_T1 = 4'b0001,
    XF_T2 = 4'b0010,
    XF_T3 = 4'b0100,
    XF_T4 = 4'b1000
  } xf_phase_t;

endpackage : xf_pkg

/* rtl/xf_phase_gen.sv */
`timescale 1ns/1ps

module xf_phase_gen
  import xf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // phase
  output logic t4
);

  xf_phase_t state_r;
  xf_phase_t state_nxt;

  // ****************************************************************
  // four phase microcycle
  // ****************************************************************
  always_comb
  begin
    case (state_r)
      XF_T1: state_nxt = XF_T2;
      XF_T2: state_nxt = XF_T3;
      XF_T3: state_nxt = XF_T4;
      XF_T4: state_nxt = XF_T1;
      default: state_nxt = XF_T1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= XF_T1;
    else
      state_r <= state_nxt;
  end

  assign t4 = (state_r == XF_T4);

  sequence s_gap;
    !t4 [*3];
  endsequence

  property p_t4_period;
    @(posedge clk) disable iff (srst) t4 |=> s_gap ##1 t4;
  endproperty
  a_t4_period: assert property (p_t4_period)
    else $error("t4 not every fourth cycle");

endmodule : xf_phase_gen

/* rtl/xf_auto_decode.sv */
`timescale 1ns/1ps
`include "xf_cfg.svh"

module xf_auto_decode
  import xf_pkg::*;
(
  // held instruction
  input wire logic [`XF_IR_W-1:0] ir,
  input wire logic delta_zero,
  // selected position
  output logic [`XF_SEL_W-1:0] pos
);

  // ****************************************************************
  // automatic position, 8 through f only
  // ****************************************************************
  wire [3:0] f_op = ir[15:12];
  wire [3:0] f1 = ir[11:8];
  wire org_m_n = ir[3];
  logic [`XF_SEL_W-1:0] st_pos;
  logic [`XF_SEL_W-1:0] rg_pos;

  always_comb
  begin
    st_pos = `XF_POS_F1A;
    if (f1 == `XF_F_ZERO)
      st_pos = delta_zero ? `XF_POS_F1 : `XF_POS_F;
    else if (f1 < `XF_F1_IR && f1[2] == 1'b0)
      st_pos = (f1 == 4'h3 && !delta_zero) ? `XF_POS_FM : 
               (delta_zero ? `XF_POS_F1A : `XF_POS_F);
    else if (f1 < `XF_F1_IR)
      st_pos = `XF_POS_F1A;
    else if (f1 == `XF_F1_IR)
      st_pos = delta_zero ? `XF_POS_F1 : `XF_POS_F;
    else if (f1[3:2] == 2'h2)
      st_pos = `XF_POS_F1;
    else
      st_pos = delta_zero ? `XF_POS_FM : `XF_POS_F1A;
  end

  assign rg_pos = (f1 == `XF_F1_SK) ? `XF_POS_SK :
                  (f1 == `XF_F1_SH) ? `XF_POS_SH :
                  (f1 == `XF_F1_IR) ? (org_m_n ? `XF_POS_IR : `XF_POS_IM) :
                  `XF_POS_F1;
  assign pos = (f_op == `XF_F_ZERO) ? rg_pos : st_pos;

endmodule : xf_auto_decode

/* rtl/xf_transform.sv */
// Functional notes
// - 16-bit instruction hold from macro memory
// - read then gate command loads instruction
// - strobe field 011xxxx gives T4 load strobe
// - held instruction feeds selectors and decoders
// - 8-bit delta hold from macro memory
// - delta loads only under gate-then-auto
// - delta feeds address and k/n selectors
// - address selector 8 bits, 16 positions
// - position equals j, auto for gate-auto
// - auto picks positions 8 through f
// - select lines from j else decoder
// - 8-f basic, others enhanced set
// - patterns from constants, registers, source, conditions
// - positions 0-4 interrupt through commercial dispatch
// - 5 zero, 6 mode, 7 source low
// - 8 skip, 9 shift, a inter-register
// - b opcode, c memory origin, d-f modes
// - enhanced dispatch through position d
// - decode indirect, protect, delta-zero conditions
// - k/n selector 8 bits, 8 positions
// - k/n position from low three bits
// - gate-auto loads k from position 7
`timescale 1ns/1ps
`include "xf_cfg.svh"

module xf_transform
  import xf_pkg::*;
#(
  parameter int IR_W = `XF_IR_W,
  parameter int DL_W = `XF_DL_W
)
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  // macro memory and cpu
  input wire logic [IR_W-1:0] i_mem_rd_data,
  input wire logic [IR_W-1:0] i_cpu_src,
  // microinstruction
  input wire xf_mir_t i_mir,
  // special condition inputs
  input wire logic i_protect_violation,
  input wire logic i_multilevel_ind,
  // hold registers
  output logic [IR_W-1:0] o_instr_hold,
  output logic [DL_W-1:0] o_delta_hold,
  // address result
  output logic [7:0] o_micro_address,
  output logic o_ma_valid,
  // k and n result
  output logic [7:0] o_kn_value,
  output logic o_k_load,
  output logic o_n_load,
  // strobes and status
  output logic o_sync_strobe,
  output logic o_auto_gate,
  output xf_cond_t o_cond
);

  // ****************************************************************
  // timing
  // ****************************************************************
  logic t4;

  xf_phase_gen u_phase (
    .clk(I_CLK_SYS),
    .srst(I_SRST),
    .t4(t4)
  );

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire cmd_git_j = (i_mir.cmd == `XF_CMD_GIT_J);
  wire cmd_git_xt = (i_mir.cmd == `XF_CMD_GIT_XT);
  wire stb_hit = (i_mir.strobe[`XF_STB_HI:`XF_STB_LO] == `XF_STB_PAT);
  wire ir_load = t4 & (cmd_git_j | cmd_git_xt | stb_hit);
  wire dl_load = t4 & cmd_git_xt;
  wire ma_cmd = (i_mir.cmd == `XF_CMD_TMA) | (i_mir.cmd == `XF_CMD_TMAK) |
                cmd_git_j | cmd_git_xt;
  wire k_cmd = (i_mir.cmd == `XF_CMD_TK) | (i_mir.cmd == `XF_CMD_TMAK) |
               cmd_git_j | cmd_git_xt;
  wire n_cmd = (i_mir.cmd == `XF_CMD_TN);

  // ****************************************************************
  // hold registers
  // ****************************************************************
  logic [IR_W-1:0] ir_r;
  logic [DL_W-1:0] dl_r;
  logic [IR_W-1:0] ir_nxt;
  logic [DL_W-1:0] dl_nxt;

  assign ir_nxt = ir_load ? i_mem_rd_data : ir_r;
  assign dl_nxt = dl_load ? i_mem_rd_data[DL_W-1:0] : dl_r;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      ir_r <= '0;
      dl_r <= '0;
    end
    else
    begin
      ir_r <= ir_nxt;
      dl_r <= dl_nxt;
    end
  end

  // ****************************************************************
  // latched command for the step after t4
  // ****************************************************************
  logic step_r;
  logic ma_r;
  logic k_r;
  logic n_r;
  logic xt_r;
  logic [`XF_SEL_W-1:0] j_r;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      step_r <= 1'b0;
      ma_r <= 1'b0;
      k_r <= 1'b0;
      n_r <= 1'b0;
      xt_r <= 1'b0;
      j_r <= '0;
    end
    else
    begin
      step_r <= t4;
      ma_r <= t4 & ma_cmd;
      k_r <= t4 & k_cmd;
      n_r <= t4 & n_cmd;
      xt_r <= t4 & cmd_git_xt;
      j_r <= t4 ? i_mir.j : j_r;
    end
  end

  // ****************************************************************
  // special conditions
  // ****************************************************************
  wire [3:0] f1 = ir_r[11:8];
  wire cond_b = (f1[3:2] == `XF_IND_PAT) | i_multilevel_ind;
  wire cond_c = i_protect_violation;
  wire cond_d = (dl_r == '0) | cond_c;
  wire f_zero = (ir_r[15:12] == `XF_F_ZERO);

  // ****************************************************************
  // position select
  // ****************************************************************
  logic [`XF_SEL_W-1:0] auto_pos;

  xf_auto_decode u_auto (
    .ir(ir_r),
    .delta_zero(dl_r == '0),
    .pos(auto_pos)
  );

  wire [`XF_SEL_W-1:0] ma_sel = xt_r ? auto_pos : j_r;
  wire [`XF_KN_SEL_W-1:0] kn_sel = xt_r ? `XF_KN_AUTO : j_r[`XF_KN_SEL_W-1:0];

  // ****************************************************************
  // address selector patterns
  // ****************************************************************
  function automatic logic [7:0] ma_pat(input logic [3:0] sel,
                                        input logic [15:0] ir,
                                        input logic [7:0] dl,
                                        input logic [15:0] src,
                                        input logic fz,
                                        input xf_cond_t cd);
    case (sel)
      4'h0: ma_pat = {4'h9, dl[3:0]};
      4'h1: ma_pat = {5'h17, dl[4:3], 1'b0};
      4'h2: ma_pat = {5'h1b, dl[2:0]};
      4'h3: ma_pat = {5'h07, dl[2:0]};
      4'h4: ma_pat = {3'h7, dl[4:0]};
      4'h5: ma_pat = 8'h00;
      4'h6: ma_pat = {4'h6, ir[11:8]};
      4'h7: ma_pat = src[7:0];
      4'h8: ma_pat = {3'h6, dl[7:4], 1'b0};
      4'h9: ma_pat = {5'h16, dl[7:5]};
      4'ha: ma_pat = {4'he, ir[3:0]};
      4'hb: ma_pat = {3'h4, ir[15:12], 1'b0};
      4'hc: ma_pat = {4'hf, dl[7:4]};
      4'hd: ma_pat = {2'h1, fz, ir[11:8], (dl == 8'h00)};
      4'he: ma_pat = {5'h14, cd.ind_b, ir[9:8]};
      default: ma_pat = {6'h2e, cd.prot_c, cd.dz_d};
    endcase
  endfunction : ma_pat

  // ****************************************************************
  // k/n selector patterns
  // ****************************************************************
  function automatic logic [7:0] kn_pat(input logic [2:0] sel,
                                        input logic [15:0] ir,
                                        input logic [7:0] dl);
    case (sel)
      3'h0: kn_pat = dl;
      3'h1: kn_pat = ir[15:8];
      3'h2: kn_pat = {4'h0, dl[3:0]};
      3'h3: kn_pat = {4'h0, dl[7:4]};
      3'h4: kn_pat = {5'h00, ir[2:0]};
      3'h5: kn_pat = {5'h00, ir[6:4]};
      3'h6: kn_pat = {4'h0, ir[15:12]};
      default: kn_pat = {4'h0, ir[11:8]};
    endcase
  endfunction : kn_pat

  xf_cond_t cond_w;
  assign cond_w = '{ind_b: cond_b, prot_c: cond_c, dz_d: cond_d};
  wire [7:0] ma_w = ma_pat(ma_sel, ir_r, dl_r, i_cpu_src, f_zero, cond_w);
  wire [7:0] kn_w = kn_pat(kn_sel, ir_r, dl_r);

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      o_micro_address <= 8'h00;
      o_ma_valid <= 1'b0;
      o_kn_value <= 8'h00;
      o_k_load <= 1'b0;
      o_n_load <= 1'b0;
      o_sync_strobe <= 1'b0;
      o_auto_gate <= 1'b0;
      o_cond <= '0;
    end
    else
    begin
      o_micro_address <= (step_r & ma_r) ? ma_w : o_micro_address;
      o_ma_valid <= step_r & ma_r;
      o_kn_value <= (step_r & (k_r | n_r)) ? kn_w : o_kn_value;
      o_k_load <= step_r & k_r;
      o_n_load <= step_r & n_r;
      o_sync_strobe <= t4 & stb_hit;
      o_auto_gate <= dl_load;
      o_cond <= cond_w;
    end
  end

  assign o_instr_hold = ir_r;
  assign o_delta_hold = dl_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_ir_taken;
    t4 ##0 ir_load;
  endsequence

  property p_ir_load;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      s_ir_taken |=> (o_instr_hold == $past(i_mem_rd_data));
  endproperty
  a_ir_load: assert property (p_ir_load)
    else $error("instruction hold not loaded");

  property p_ir_keep;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      !ir_load |=> $stable(o_instr_hold);
  endproperty
  a_ir_keep: assert property (p_ir_keep)
    else $error("instruction hold changed without load");

  property p_dl_only_auto;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      !(t4 && cmd_git_xt) |=> $stable(o_delta_hold);
  endproperty
  a_dl_only_auto: assert property (p_dl_only_auto)
    else $error("delta hold changed outside gate-auto");

  property p_strobe;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      (t4 && stb_hit) |=> o_sync_strobe ##1 !o_sync_strobe;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("sync strobe wrong");

  property p_auto_range;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      (step_r && xt_r) |-> ma_sel[3];
  endproperty
  a_auto_range: assert property (p_auto_range)
    else $error("auto position below 8");

  property p_sel_j;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      (t4 && ma_cmd && !cmd_git_xt) |=> (ma_sel == $past(i_mir.j));
  endproperty
  a_sel_j: assert property (p_sel_j)
    else $error("address position not j");

  property p_pos_zero;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      (step_r && ma_r && ma_sel == `XF_POS_ZERO) |=> (o_micro_address == 8'h00);
  endproperty
  a_pos_zero: assert property (p_pos_zero)
    else $error("position 5 not zero");

  property p_pos_src;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      (step_r && ma_r && ma_sel == `XF_POS_SRC) |=>
        (o_micro_address == $past(i_cpu_src[7:0]));
  endproperty
  a_pos_src: assert property (p_pos_src)
    else $error("position 7 not source low byte");

  property p_k_auto;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
      (t4 && cmd_git_xt) |=> ##1 (o_k_load && o_ma_valid &&
        o_kn_value == {4'h0, o_instr_hold[11:8]});
  endproperty
  a_k_auto: assert property (p_k_auto)
    else $error("gate-auto k not from position 7");

endmodule : xf_transform

/* verification/xf_seq_model.sv */
`timescale 1ns/1ps

module xf_seq_model
  import xf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // request from bench
  input wire logic go,
  input wire xf_mir_t req_mir,
  input wire logic [15:0] req_data,
  // toward the transform
  output xf_mir_t microinstruction_register,
  output logic [15:0] mem_data,
  output logic busy
);
  // ****************************************************************
  // one microinstruction held for a full microcycle
  // ****************************************************************
  logic go_q;
  int left;

  always @(posedge clk) go_q <= go & ~srst;

  // gate commands only issued right after a read, data with them
  always @(negedge clk)
  begin
    if (srst)
    begin
      left <= 0;
      microinstruction_register <= '0;
      mem_data <= 16'h0000;
    end
    else if (go_q)
    begin
      microinstruction_register <= req_mir;
      mem_data <= req_data;
      left <= 4;
    end
    else if (left > 1)
      left <= left - 1;
    else
    begin
      left <= 0;
      microinstruction_register <= '0;
      mem_data <= ~mem_data;
    end
  end

  assign busy = go_q | (left != 0);
endmodule : xf_seq_model

/* verification/tb_xf_transform.sv */
`timescale 1ns/1ps

module tb_xf_transform
  import xf_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic I_CLK_SYS = 1'b0;
  logic I_SRST = 1'b1;
  logic go = 1'b0;
  xf_mir_t req_mir = '0;
  logic [15:0] req_data = 16'h0000;
  logic [15:0] cpu_src = 16'h0000;
  logic prot = 1'b0;
  logic mlind = 1'b0;
  xf_mir_t microinstruction_register;
  logic [15:0] mem_data;
  logic busy;
  logic [15:0] instr;
  logic [7:0] delta;
  logic [7:0] addr;
  logic [7:0] kn;
  logic ma_valid;
  logic k_load;
  logic n_load;
  logic sync;
  logic agate;
  xf_cond_t cond;
  int n_errors = 0;
  int compares = 0;
  wire [5:0] pulses = {busy, k_load, n_load, sync, agate, ma_valid};

  always #25 I_CLK_SYS = ~I_CLK_SYS;

  xf_seq_model u_seq (.clk(I_CLK_SYS), .srst(I_SRST), .go(go), .req_mir(req_mir),
    .req_data(req_data), .microinstruction_register(microinstruction_register), .mem_data(mem_data), .busy(busy));

  xf_transform u_dut (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .i_mem_rd_data(mem_data),
    .i_cpu_src(cpu_src), .i_mir(microinstruction_register), .i_protect_violation(prot),
    .i_multilevel_ind(mlind), .o_instr_hold(instr), .o_delta_hold(delta),
    .o_micro_address(addr), .o_ma_valid(ma_valid), .o_kn_value(kn), .o_k_load(k_load),
    .o_n_load(n_load), .o_sync_strobe(sync), .o_auto_gate(agate), .o_cond(cond));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic wrap_up;
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask : cmp1

  task automatic tick_until(input int w, input logic lvl);
    int n;
    n = 0;
    while (pulses[w] !== lvl && n < 12)
    begin
      @(negedge I_CLK_SYS);
      n++;
    end
    if (n == 12)
    begin
      n_errors++;
      wrap_up();
    end
  endtask : tick_until

  task automatic issue(input logic [3:0] cmd, input logic [3:0] j, input logic [6:0] stb,
                       input logic [15:0] data, input int w);
    tick_until(5, 1'b0);
    req_mir = '{cmd: cmd, strobe: stb, j: j};
    req_data = data;
    go = 1'b1;
    @(negedge I_CLK_SYS);
    go = 1'b0;
    tick_until(w, 1'b1);
  endtask : issue

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_sync;
    issue(4'h0, 4'h0, 7'b0110101, 16'hbeef, 2);
    cmp16(instr, 16'hbeef);
    cmp8(delta, 8'h00);
    cmp1(agate, 1'b0);
  endtask : t_sync

  task automatic t_auto;
    logic [15:0] d [6] = '{16'h015a, 16'h0fe0, 16'h080b, 16'h0834, 16'h2903, 16'h1c00};
    logic [7:0] e [6] = '{8'hca, 8'hb7, 8'heb, 8'hf3, 8'h52, 8'hb9};
    for (int i = 0; i < 6; i++)
    begin
      issue(4'h6, 4'h0, 7'h00, d[i], 1);
      cmp16(instr, d[i]);
      cmp8(delta, d[i][7:0]);
      tick_until(0, 1'b1);
      cmp8(addr, e[i]);
      cmp1(k_load, 1'b1);
      cmp8(kn, {4'h0, d[i][11:8]});
    end
  endtask : t_auto

  task automatic t_cond;
    prot = 1'b1;
    mlind = 1'b1;
    issue(4'h6, 4'h0, 7'h00, 16'h1c00, 0);
    cmp8(addr, 8'hbb);
    cmp8({5'h00, cond}, 8'h07);
    issue(4'h6, 4'h0, 7'h00, 16'h2903, 0);
    cmp8(addr, 8'h52);
    issue(4'h6, 4'h0, 7'h00, 16'h3456, 0);
    cmp8(addr, 8'ha4);
    prot = 1'b0;
    mlind = 1'b0;
  endtask : t_cond

  task automatic t_j;
    cpu_src = 16'h12a5;
    issue(4'h1, 4'h5, 7'h00, 16'h0000, 0);
    cmp8(addr, 8'h00);
    issue(4'h1, 4'h7, 7'h00, 16'h0000, 0);
    cmp8(addr, 8'ha5);
    cmp1(k_load, 1'b0);
    issue(4'h2, 4'h5, 7'h00, 16'h0000, 4);
    cmp1(ma_valid, 1'b1);
    cmp8(addr, 8'h00);
    issue(4'h5, 4'h7, 7'h00, 16'h0c77, 0);
    cmp16(instr, 16'h0c77);
    cmp8(delta, 8'h56);
    cmp8(addr, 8'ha5);
    cmp1(k_load, 1'b1);
  endtask : t_j

  task automatic t_kn;
    issue(4'h4, 4'h0, 7'h00, 16'h0000, 3);
    cmp8(kn, 8'h56);
    cmp1(k_load, 1'b0);
    issue(4'h3, 4'hf, 7'h00, 16'h0000, 4);
    cmp8(kn, 8'h0c);
    cmp1(ma_valid, 1'b0);
    cmp16(instr, 16'h0c77);
    cmp8(delta, 8'h56);
  endtask : t_kn

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (10) @(negedge I_CLK_SYS);
    I_SRST = 1'b0;
    t_sync();
    t_auto();
    t_cond();
    t_j();
    t_kn();
    wrap_up();
  end
endmodule : tb_xf_transform
